// ---- fbsp_array.sv ----
// byte-lane masked memory core with combinational read
`timescale 1ns/10ps
`default_nettype none
module fbsp_array
  import fbsp_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    wr_valid,
  output logic                         wr_ready,
  input  wire fbsp_wr_t                wr,
  input  wire logic [`FBSP_ADDR_W-1:0] rd_addr,
  output logic      [`FBSP_DATA_W-1:0] rd_data
);
  logic [`FBSP_DATA_W-1:0] mem_q [`FBSP_DEPTH];
  wire logic [`FBSP_DATA_W-1:0] old_word;
  wire logic [`FBSP_DATA_W-1:0] new_word;

  assign wr_ready = 1'b1;
  // flow-through: read path is pure combinational lookup
  assign rd_data  = mem_q[rd_addr];

  assign old_word = mem_q[wr.addr];

  genvar g;
  generate
    for (g = 0; g < `FBSP_LANES; g++)
    begin : g_lane
      // a lane is one data byte plus its own parity bit
      assign new_word[8*g +: 8] = wr.lane_n[g] ? old_word[8*g +: 8]
                                               : wr.data[8*g +: 8];
      assign new_word[32+g]     = wr.lane_n[g] ? old_word[32+g]
                                               : wr.data[32+g];
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (wr_valid)
      mem_q[wr.addr] <= new_word;
  end
endmodule // fbsp_array
`default_nettype wire

// ---- fbsp_consts.svh ----
// constants for the flow-through burst sram port
`ifndef FBSP_CONSTS_SVH
`define FBSP_CONSTS_SVH
`define FBSP_ADDR_W   10
`define FBSP_LANES    4
`define FBSP_LANE_W   9
`define FBSP_DATA_W   36
`define FBSP_DEPTH    1024
`define FBSP_FIFO_D   8
`define FBSP_FIFO_AW  3
`define FBSP_BURST_W  2
`endif

// ---- fbsp_ctrl_model.sv ----
// memory controller model on the port's pins
`timescale 1ns/10ps
`default_nettype none
module fbsp_ctrl_model
  import fbsp_pkg::*;
(
  input  wire logic        clk,
  input  wire fbsp_op_t    cop,
  input  wire logic        adv,
  input  wire logic [1:0]  dk,
  input  wire logic        drv,
  input  wire logic [35:0] wd,
  input  wire logic [3:0]  ln,
  input  wire logic [31:0] dq_out,
  input  wire logic [3:0]  parity_lane_out,
  input  wire logic        dq_oe,
  output logic             select_first_n,
  output logic             select_second,
  output logic             select_third_n,
  output logic             advance_or_load,
  output logic             write_n,
  output logic [3:0]       byte_lane_write_n,
  output logic [31:0]      dq_in,
  output logic [3:0]       parity_lane_in
);
  logic s;
  logic t = 1'h0;
  logic [35:0] bus;
  always @(posedge clk) t <= ~t;
  assign s = cop != FBSP_IDLE;
  // one inactive select of three is enough to deselect
  assign select_first_n = !s && dk == 2'h0;
  assign select_second = s || dk != 2'h1;
  assign select_third_n = !s && dk == 2'h2;
  assign advance_or_load = adv;
  assign write_n = cop != FBSP_WRITE;
  assign byte_lane_write_n = ln;
  // released bus toggles so stale data never passes
  assign bus = drv ? wd : dq_oe ? {parity_lane_out, dq_out} : {18{t, ~t}};
  assign dq_in = bus[31:0];
  assign parity_lane_in = bus[35:32];
endmodule // fbsp_ctrl_model
`default_nettype wire

// ---- fbsp_fifo.sv ----
// parameterised valid/ready fifo
`timescale 1ns/10ps
`default_nettype none
module fbsp_fifo
  import fbsp_pkg::*;
#(
  parameter int W  = `FBSP_DATA_W,
  parameter int D  = `FBSP_FIFO_D,
  parameter int AW = `FBSP_FIFO_AW
)
(
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  logic [W-1:0] mem_q [D];
  logic [AW:0]  wp_q;
  logic [AW:0]  wp_d;
  logic [AW:0]  rp_q;
  logic [AW:0]  rp_d;
  logic         push;
  logic         pop;

  always_comb
  begin
    in_ready  = (wp_q - rp_q) != (AW+1)'(D);
    out_valid = wp_q != rp_q;
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    wp_d      = wp_q + (AW+1)'(push);
    rp_d      = rp_q + (AW+1)'(pop);
    out_data  = mem_q[rp_q[AW-1:0]];
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wp_q <= '0;
      rp_q <= '0;
    end
    else
    begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
  end

  // storage has no reset: contents are only read once written
  always_ff @(posedge clk)
  begin
    if (push)
      mem_q[wp_q[AW-1:0]] <= in_data;
  end
endmodule // fbsp_fifo
`default_nettype wire

// ---- fbsp_pkg.sv ----
// types for the flow-through burst sram port
`include "fbsp_consts.svh"
package fbsp_pkg;
  typedef struct packed {
    logic [`FBSP_ADDR_W-1:0] addr;
    logic [`FBSP_DATA_W-1:0] data;
    logic [`FBSP_LANES-1:0]  lane_n;
  } fbsp_wr_t;
  typedef enum logic [1:0] {
    FBSP_IDLE = 2'b00,
    FBSP_READ = 2'b01,
    FBSP_WRITE = 2'b10
  } fbsp_op_t;
endpackage

// ---- fbsp_port.sv ----
// flow-through burst sram access port top
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - inputs registered on rising clock edge
// - qualifier high holds all state except queued writes, which still drain
// - selected, write high, load low: read
// - read data driven only with enable low
// - new command accepted right after read
// - deselect floats outputs after the same one-stage pipeline as a read
// - burst counter covers four accesses
// - order pin: low linear, high interleaved
// - counter wraps in low two bits
// - advance ignores selects and write select
// - access type fixed for whole burst
// - write start loads address, floats bus
// - write data latched next edge
// - only selected byte lanes written
// - bus floated in write data phase
// - all operations pipelined one stage
// - select needs first low, second high, third low
// - interleave xor, linear add modulo four
// - powers up deselected and floating
// - enable masked first cycle after deselect
module fbsp_port
  import fbsp_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  input  wire logic                    clock_qualify_n,
  input  wire logic                    select_first_n,
  input  wire logic                    select_second,
  input  wire logic                    select_third_n,
  input  wire logic                    advance_or_load,
  input  wire logic                    write_n,
  input  wire logic [`FBSP_LANES-1:0]  byte_lane_write_n,
  input  wire logic [`FBSP_ADDR_W-1:0] addr,
  input  wire logic                    burst_order,
  input  wire logic                    out_enable_n,
  input  wire logic [31:0]             dq_in,
  input  wire logic [`FBSP_LANES-1:0]  parity_lane_in,
  output logic      [31:0]             dq_out,
  output logic      [`FBSP_LANES-1:0]  parity_lane_out,
  output logic                         dq_oe
);
  fbsp_op_t                  op_q;
  fbsp_op_t                  op_d;
  logic [`FBSP_ADDR_W-1:0]   base_q;
  logic [`FBSP_ADDR_W-1:0]   base_d;
  logic [1:0]                beat_q;
  logic [1:0]                beat_d;
  logic                      order_q;
  logic                      order_d;
  logic                      fresh_q;
  logic                      fresh_d;
  logic [`FBSP_DATA_W-1:0]   rdata_q;
  logic [`FBSP_DATA_W-1:0]   rdata_d;
  logic [`FBSP_DATA_W-1:0]   core_rd;
  logic [`FBSP_ADDR_W-1:0]   cur_addr;
  logic [1:0]                low_bits;
  logic                      selected;
  logic                      go;
  fbsp_wr_t                  wr_pkt;
  logic                      wr_push;
  logic                      wr_ready;
  logic                      fifo_valid;
  logic                      core_ready;
  fbsp_wr_t                  fifo_pkt;

  // output stage: data and its drive qualifiers
  logic                      rd_out_q;
  logic                      rd_out_d;
  logic                      mask_q;
  logic                      mask_d;

  // pins come from another clock domain's logic and are synchronised
  logic [`FBSP_ADDR_W+`FBSP_LANES+7:0] s1_q;
  logic [`FBSP_ADDR_W+`FBSP_LANES+7:0] s2_q;
  logic [`FBSP_ADDR_W+`FBSP_LANES+7:0] s_raw;
  logic [35:0]               ds1_q;
  logic [35:0]               ds2_q;
  logic                      oe1_q;
  logic                      oe2_q;
  logic [`FBSP_ADDR_W+`FBSP_LANES+7:0] s1_d;
  logic [`FBSP_ADDR_W+`FBSP_LANES+7:0] s2_d;
  logic [35:0]               ds1_d;
  logic [35:0]               ds2_d;
  logic                      oe1_d;
  logic                      oe2_d;

  logic                      qn;
  logic                      s1n;
  logic                      s2;
  logic                      s3n;
  logic                      adv;
  logic                      wn;
  logic                      ord;
  logic [`FBSP_LANES-1:0]    lanes_n;
  logic [`FBSP_ADDR_W-1:0]   a_in;

  assign s_raw = {clock_qualify_n, select_first_n, select_second,
                  select_third_n, advance_or_load, write_n, burst_order,
                  byte_lane_write_n, addr, 1'b0};

  // second stage reads only the first; no logic sees stage one
  always_comb
  begin
    s1_d  = s_raw;
    s2_d  = s1_q;
    ds1_d = {parity_lane_in, dq_in};
    ds2_d = ds1_q;
    oe1_d = out_enable_n;
    oe2_d = oe1_q;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s1_q  <= '0;
      s2_q  <= '0;
      ds1_q <= '0;
      ds2_q <= '0;
      oe1_q <= 1'b1;
      oe2_q <= 1'b1;
    end
    else
    begin
      s1_q  <= s1_d;
      s2_q  <= s2_d;
      ds1_q <= ds1_d;
      ds2_q <= ds2_d;
      oe1_q <= oe1_d;
      oe2_q <= oe2_d;
    end
  end

  always_comb
  begin
    {qn, s1n, s2, s3n, adv, wn, ord, lanes_n, a_in} =
      s2_q[`FBSP_ADDR_W+`FBSP_LANES+7:1];
  end

  assign go       = !qn;
  assign selected = !s1n && s2 && !s3n;

  // burst address generator
  always_comb
  begin
    if (order_q)
      low_bits = base_q[1:0] ^ beat_q;
    else
      low_bits = base_q[1:0] + beat_q;
    cur_addr = {base_q[`FBSP_ADDR_W-1:2], low_bits};
  end

  // write packet issued when the data edge arrives
  always_comb
  begin
    wr_pkt.addr   = cur_addr;
    wr_pkt.data   = ds2_q;
    wr_pkt.lane_n = lanes_n;
    wr_push       = go && op_q == FBSP_WRITE;
  end

  always_comb
  begin
    op_d    = op_q;
    base_d  = base_q;
    beat_d  = beat_q;
    order_d = order_q;
    fresh_d = fresh_q;
    // a full write queue stalls the port like a held qualifier
    if (go && wr_ready)
    begin
      fresh_d = op_q == FBSP_IDLE;
      if (adv)
      begin
        // type kept from burst start, selects ignored
        if (op_q != FBSP_IDLE)
          beat_d = beat_q + 2'h1;
      end
      else if (!selected)
      begin
        op_d = FBSP_IDLE;
      end
      else
      begin
        base_d  = a_in;
        beat_d  = 2'h0;
        order_d = ord;
        op_d    = wn ? FBSP_READ : FBSP_WRITE;
      end
    end
  end


  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      op_q    <= FBSP_IDLE;
      base_q  <= '0;
      beat_q  <= 2'h0;
      order_q <= 1'b0;
      fresh_q <= 1'b0;
    end
    else
    begin
      op_q    <= op_d;
      base_q  <= base_d;
      beat_q  <= beat_d;
      order_q <= order_d;
      fresh_q <= fresh_d;
    end
  end

  // the drive qualifiers travel with the data they belong to, so a
  // following command cannot float or mask a beat still on the bus
  always_comb
  begin
    rdata_d  = rdata_q;
    rd_out_d = rd_out_q;
    mask_d   = mask_q;
    if (go && wr_ready)
    begin
      rdata_d  = core_rd;
      rd_out_d = op_q == FBSP_READ;
      mask_d   = fresh_q;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rdata_q  <= '0;
      rd_out_q <= 1'b0;
      mask_q   <= 1'b1;
    end
    else
    begin
      rdata_q  <= rdata_d;
      rd_out_q <= rd_out_d;
      mask_q   <= mask_d;
    end
  end


  fbsp_fifo #(
    .W  ($bits(fbsp_wr_t)),
    .D  (`FBSP_FIFO_D),
    .AW (`FBSP_FIFO_AW)
  ) u_fifo (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_valid  (wr_push),
    .in_ready  (wr_ready),
    .in_data   (wr_pkt),
    .out_valid (fifo_valid),
    .out_ready (core_ready),
    .out_data  (fifo_pkt)
  );

  // reads see the array; queued writes lag a few cycles, a known limit
  fbsp_array u_array (
    .clk      (clk),
    .wr_valid (fifo_valid),
    .wr_ready (core_ready),
    .wr       (fifo_pkt),
    .rd_addr  (cur_addr),
    .rd_data  (core_rd)
  );

  always_comb
  begin
    dq_out          = rdata_q[31:0];
    parity_lane_out = rdata_q[35:32];
    dq_oe = !oe2_q && rd_out_q && !mask_q;
  end
endmodule // fbsp_port
`default_nettype wire

// ---- fbsp_port_props.sv ----
// assertions on the sram port pins
`timescale 1ns/10ps
`default_nettype none
module fbsp_port_props
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clock_qualify_n,
  input wire logic select_first_n,
  input wire logic select_second,
  input wire logic select_third_n,
  input wire logic advance_or_load,
  input wire logic write_n,
  input wire logic out_enable_n,
  input wire logic dq_oe
);
  wire q, e, sel, rd, wr, ds;
  assign q = !clock_qualify_n;
  assign e = q && !out_enable_n;
  assign sel = !select_first_n && select_second && !select_third_n;
  assign rd = q && sel && !advance_or_load && write_n;
  assign wr = q && sel && !advance_or_load && !write_n;
  assign ds = q && !sel && !advance_or_load;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // pins pass two sync flops, so windows are a few cycles long
  chk_oe_gate: assert property (out_enable_n[*5] |-> !dq_oe)
    else $error("drive with enable high");
  chk_qual_hold: assert property
    ((clock_qualify_n && $stable(out_enable_n))[*5] |=> $stable(dq_oe))
    else $error("moved while suspended");
  chk_desel_float: assert property (ds[*5] |-> !dq_oe)
    else $error("drive while deselected");
  chk_write_float: assert property (wr ##1 q[*4] |-> !dq_oe)
    else $error("drive in write data phase");
  chk_idle_mask: assert property (ds ##1 rd ##1 q[*4] |-> !dq_oe)
    else $error("enable not masked after idle");
  chk_read_drive: assert property
    ((rd && e) ##1 (rd && e) ##1 e[*4] |-> dq_oe)
    else $error("back to back read not driven");
  chk_burst_drive: assert property
    ((rd && e) ##1 (e && advance_or_load)[*2] ##1 e[*4] |-> dq_oe)
    else $error("burst beat not driven");
  chk_read_desel: assert property (rd ##1 ds ##1 q[*4] |-> !dq_oe)
    else $error("drive after deselect");
endmodule // fbsp_port_props
bind fbsp_port fbsp_port_props u_props (.clk(clk), .rst_b(rst_b),
  .clock_qualify_n(clock_qualify_n), .select_first_n(select_first_n),
  .select_second(select_second), .select_third_n(select_third_n),
  .advance_or_load(advance_or_load), .write_n(write_n),
  .out_enable_n(out_enable_n), .dq_oe(dq_oe));
`default_nettype wire

// ---- fbsp_port_tb.sv ----
// self-checking bench for the burst sram port
`timescale 1ns/10ps
`default_nettype none
`define CK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; \
  $display("Error %0t: got %h want %h", $time, g, e); end end
module fbsp_port_tb
  import fbsp_pkg::*;
;
  typedef struct {int t; logic oe; logic [35:0] d;} fbsp_note_t;
  logic clk = 0, rst_b = 0, qn = 1, adv = 0, drv = 0, ord = 1, oen = 0;
  fbsp_op_t cop = FBSP_IDLE;
  logic [1:0] dk = 2'h0;
  logic [9:0] a = 10'h0;
  logic [35:0] wd = 36'h0;
  logic [3:0] ln = 4'hf;
  logic [35:0] mem [1024];
  fbsp_note_t nq [$];
  fbsp_note_t nt;
  int cyc = 0, failures = 0, n_compared = 0;
  logic [31:0] s = 32'h2687;
  wire sf, s2, s3, al, wn, oe;
  wire [3:0] bl, pi, po;
  wire [31:0] dqi, dqo;
  fbsp_ctrl_model u_ctrl (.clk(clk), .cop(cop), .adv(adv), .dk(dk),
    .drv(drv), .wd(wd), .ln(ln), .dq_out(dqo), .parity_lane_out(po),
    .dq_oe(oe), .select_first_n(sf), .select_second(s2),
    .select_third_n(s3), .advance_or_load(al), .write_n(wn),
    .byte_lane_write_n(bl), .dq_in(dqi), .parity_lane_in(pi));
  fbsp_port uut (.clk(clk), .rst_b(rst_b), .clock_qualify_n(qn),
    .select_first_n(sf), .select_second(s2), .select_third_n(s3),
    .advance_or_load(al), .write_n(wn), .byte_lane_write_n(bl), .addr(a),
    .burst_order(ord), .out_enable_n(oen), .dq_in(dqi),
    .parity_lane_in(pi), .dq_out(dqo), .parity_lane_out(po), .dq_oe(oe));
  function automatic logic [31:0] rnd();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  function automatic logic [9:0] beat(logic [9:0] b, int k);
    return {b[9:2], ord ? b[1:0] ^ 2'(k) : b[1:0] + 2'(k)};
  endfunction
  task automatic step(fbsp_op_t o, logic v);
    @(posedge clk);
    cop <= o;
    adv <= v;
    dk <= 2'(rnd() % 3);
  endtask
  task automatic rd(logic [9:0] b, int n, logic m);
    for (int k = 0; k < n; k++)
    begin
      step(k ? FBSP_IDLE : FBSP_READ, k != 0);
      a <= k ? 10'(rnd()) : b;
      nq.push_back('{cyc + 5, !oen && !(m && k == 0), mem[beat(b, k)]});
    end
  endtask
  task automatic wr(logic [9:0] b, int n, logic [3:0] l);
    logic [35:0] d;
    for (int k = 0; k <= n; k++)
    begin
      d = 36'({rnd(), rnd()});
      step(k ? FBSP_IDLE : FBSP_WRITE, k != 0 && k < n);
      a <= b;
      drv <= k != 0;
      wd <= d;
      ln <= l;
      for (int g = 0; g < 4 && k > 0; g++)
        if (!l[g])
        begin
          mem[beat(b, k - 1)][8*g+:8] = d[8*g+:8];
          mem[beat(b, k - 1)][32+g] = d[32+g];
        end
    end
    step(FBSP_IDLE, 1'b0);
    drv <= 1'b0;
  endtask
  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    forever #10 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 1000)
    begin
      failures++;
      results();
    end
    if (nq.size() != 0 && nq[0].t == cyc)
    begin
      nt = nq.pop_front();
      `CK(oe, nt.oe)
      if (nt.oe)
        `CK({po, dqo}, nt.d)
    end
  end
  initial
  begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    // qualifier still high: nothing may move yet
    repeat (6) @(posedge clk);
    qn <= 1'b0;
    wr(10'h015, 4, 4'h0);
    wr(10'h016, 1, 4'ha);
    // write queue drains before reads look at the array
    repeat (30) step(FBSP_IDLE, 1'b0);
    $display("test writes done");
    rd(10'h017, 4, 1'b1);
    rd(10'h014, 1, 1'b0);
    rd(10'h016, 4, 1'b0);
    rd(10'h015, 1, 1'b0);
    step(FBSP_IDLE, 1'b0);
    nq.push_back('{cyc + 5, 1'b0, 36'h0});
    repeat (8) step(FBSP_IDLE, 1'b0);
    $display("test interleaved done");
    ord <= 1'b0;
    repeat (8) step(FBSP_IDLE, 1'b0);
    rd(10'h015, 4, 1'b1);
    rd(10'h017, 4, 1'b0);
    repeat (8) step(FBSP_IDLE, 1'b0);
    $display("test linear done");
    oen <= 1'b1;
    repeat (6) step(FBSP_IDLE, 1'b0);
    rd(10'h014, 2, 1'b1);
    rd(10'h016, 1, 1'b0);
    repeat (8) step(FBSP_IDLE, 1'b0);
    $display("test enable high done");
    results();
  end
endmodule // fbsp_port_tb
`default_nettype wire
